/* File: rtl/rlm_chan.sv */
/*
  Zero-run loss detector and alarm state for one receive channel.
  Assumes the analog low-level flag already carries its hysteresis.
*/
`timescale 1ns/100ps
module rlm_chan import rlm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic e1_mode,
  input wire logic ext_window,
  input wire logic analog_low,
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic window_ok,
  output logic lost,
  output logic declare
);

  logic [12:0] zero_run;
  logic [12:0] limit;
  logic clear;

  assign limit = rlm_zero_limit(e1_mode, ext_window);
  // Declare on the zero that completes the run
  assign declare = !lost && analog_low && bit_valid && !bit_data
    && zero_run == limit - 13'h0001;
  assign clear = lost && !analog_low && window_ok;

  // ****************
  // Zero counter
  // ****************
  always_ff @(posedge clk) begin
    if (rst || !analog_low) begin
      zero_run <= 13'h0000;
    end else if (bit_valid) begin
      if (bit_data) begin
        zero_run <= 13'h0000;
      end else if (zero_run < limit) begin
        zero_run <= zero_run + 13'h0001;
      end
    end
  end

  // ****************
  // Live loss flag
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      lost <= 1'b0;
    end else if (declare) begin
      lost <= 1'b1;
    end else if (clear) begin
      lost <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_count_gated: assert property (!analog_low |=> zero_run == 13'h0000)
    else $error("Zero count ran without analog loss");
  a_e1_short: assert property (declare && e1_mode && !ext_window
    |-> zero_run == 13'h001F)
    else $error("E1 declare not on 32nd zero");
  a_e1_long: assert property (declare && e1_mode && ext_window
    |-> zero_run == 13'h0FFF)
    else $error("Extended E1 declare not on 4096th zero");
  a_t1_limit: assert property (declare && !e1_mode
    |-> zero_run == 13'h00AE)
    else $error("T1 declare not on 175th zero");
  a_one_resets: assert property (analog_low && bit_valid && bit_data
    |=> zero_run == 13'h0000)
    else $error("A one did not restart the zero count");
  a_clear_cause: assert property ($fell(lost)
    |-> $past(window_ok) && !$past(analog_low))
    else $error("Alarm cleared without recovery");

endmodule // rlm_chan

/* File: rtl/rlm_pkg.sv */
/*
  Constants shared by the receive loss-of-signal monitor.
  Assumes one core clock and a 32-bit APB register bus.
*/
package rlm_pkg;

  // ****************
  // Sizes
  // ****************
  localparam int unsigned RLM_NCH = 8;
  localparam int unsigned RLM_RUN_W = 13;
  localparam int unsigned RLM_WIN_W = 8;

  // ****************
  // Zero-run thresholds
  // ****************
  localparam logic [12:0] RLM_E1_ZEROS = 13'h0020;
  localparam logic [12:0] RLM_E1_EXT_ZEROS = 13'h1000;
  localparam logic [12:0] RLM_T1_ZEROS = 13'h00AF;

  // ****************
  // Recovery windows
  // ****************
  localparam logic [7:0] RLM_E1_WIN_LEN = 8'h20;
  localparam logic [7:0] RLM_E1_WIN_ONES = 8'h04;
  localparam logic [7:0] RLM_E1_WIN_RUN = 8'h10;
  localparam logic [7:0] RLM_T1_WIN_LEN = 8'h80;
  localparam logic [7:0] RLM_T1_WIN_ONES = 8'h10;
  localparam logic [7:0] RLM_T1_WIN_RUN = 8'h64;

  // ****************
  // Register map
  // ****************
  localparam logic [7:0] RLM_OFS_CONFIG = 8'h00;
  localparam logic [7:0] RLM_OFS_LIVE = 8'h04;
  localparam logic [7:0] RLM_OFS_STATUS = 8'h08;
  localparam logic [7:0] RLM_OFS_ENABLE = 8'h0C;
  localparam logic [7:0] RLM_OFS_CLEAR = 8'h10;
  localparam int unsigned RLM_CFG_E1_BIT = 0;
  localparam int unsigned RLM_CFG_EXT_BIT = 1;
  localparam logic [1:0] RLM_CONFIG_RST = 2'h0;
  localparam logic [7:0] RLM_ENABLE_RST = 8'h00;
  localparam logic [7:0] RLM_STATUS_RST = 8'h00;

  // Declaration threshold for the selected line mode
  function automatic logic [12:0] rlm_zero_limit(input logic e1,
                                                 input logic ext);
    if (!e1) begin
      return RLM_T1_ZEROS;
    end
    return ext ? RLM_E1_EXT_ZEROS : RLM_E1_ZEROS;
  endfunction

endpackage

/* File: rtl/rlm_top.sv */
/*
  Eight-channel receive loss-of-signal monitor with APB registers.
  Assumes recovered bits arrive as strobes on the core clock and
  that the analog low-level flags come from the receive equalizer.
*/
// Notes on behaviour
// - Zero counting runs only while the analog low flag is present.
// - E1, normal window: declare loss after 32 consecutive zeros.
// - E1, extended window set: declare loss after 4096 zeros.
// - T1: declare loss after 175 consecutive zeros.
// - E1 clear: level recovered, 4 ones per 32 bits, runs <= 16.
// - T1 clear: level recovered, 16 ones per 128 bits, runs <= 100.
// - A declaration updates both live loss flag and latched status.
// - Enabled latched status drives the active-low interrupt low.
// - Reading alarm status clears it, releasing the interrupt.
`timescale 1ns/100ps
module rlm_top import rlm_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] RX_ANALOG_LOW,
  input wire logic [7:0] RX_BIT_VALID,
  input wire logic [7:0] RX_BIT,
  output logic [7:0] RX_SIGNAL_LOST,
  output logic INT_N
);

  // ****************
  // Declarations
  // ****************
  logic [1:0] config_reg;
  logic [7:0] enable;
  logic [7:0] status;
  logic [7:0] lost;
  logic [7:0] declare;
  logic [7:0] window_ok;
  logic [7:0] read_mask;
  logic [7:0] next_status;
  logic e1_mode;
  logic extended_loss_window;
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;
  logic status_setup;
  logic status_read;
  logic clear_write;

  // ****************
  // Address decode
  // ****************
  function automatic logic rlm_mapped(input logic [7:0] a);
    return a == RLM_OFS_CONFIG || a == RLM_OFS_LIVE ||
           a == RLM_OFS_STATUS || a == RLM_OFS_ENABLE ||
           a == RLM_OFS_CLEAR;
  endfunction

  function automatic logic [31:0] rlm_read(input logic [7:0] a,
                                           input logic [1:0] cfg,
                                           input logic [7:0] live,
                                           input logic [7:0] stat,
                                           input logic [7:0] en);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == RLM_OFS_CONFIG) begin
      d[1:0] = cfg;
    end else if (a == RLM_OFS_LIVE) begin
      d[7:0] = live;
    end else if (a == RLM_OFS_STATUS) begin
      d[7:0] = stat;
    end else if (a == RLM_OFS_ENABLE) begin
      d[7:0] = en;
    end
    return d;
  endfunction

  assign e1_mode = config_reg[RLM_CFG_E1_BIT];
  assign extended_loss_window = config_reg[RLM_CFG_EXT_BIT];
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr_access = access && PWRITE;
  assign rd_access = access && !PWRITE;
  assign status_setup = setup && !PWRITE && PADDR == RLM_OFS_STATUS;
  assign status_read = rd_access && PADDR == RLM_OFS_STATUS;
  assign clear_write = wr_access && PADDR == RLM_OFS_CLEAR;

  // ****************
  // APB slave
  // ****************
  assign PREADY = 1'b1;
  assign PSLVERR = access && !rlm_mapped(PADDR);

  // Read data sampled in setup, stable through access
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rlm_read(PADDR, config_reg, lost, status, enable);
    end
  end

  // Only bits that went out on the bus are cleared by the read
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      read_mask <= 8'h00;
    end else if (status_setup) begin
      read_mask <= status;
    end else if (setup) begin
      read_mask <= 8'h00;
    end
  end

  // ****************
  // Control registers
  // ****************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      config_reg <= RLM_CONFIG_RST;
    end else if (wr_access && PADDR == RLM_OFS_CONFIG) begin
      config_reg <= PWDATA[1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      enable <= RLM_ENABLE_RST;
    end else if (wr_access && PADDR == RLM_OFS_ENABLE) begin
      enable <= PWDATA[7:0];
    end
  end

  // ****************
  // Channels
  // ****************
  for (genvar ch = 0; ch < RLM_NCH; ch++) begin : g_ch
    rlm_win u_win (
      .clk(CORE_CLK),
      .rst(RST),
      .e1_mode(e1_mode),
      .bit_valid(RX_BIT_VALID[ch]),
      .bit_data(RX_BIT[ch]),
      .window_ok(window_ok[ch])
    );
    rlm_chan u_chan (
      .clk(CORE_CLK),
      .rst(RST),
      .e1_mode(e1_mode),
      .ext_window(extended_loss_window),
      .analog_low(RX_ANALOG_LOW[ch]),
      .bit_valid(RX_BIT_VALID[ch]),
      .bit_data(RX_BIT[ch]),
      .window_ok(window_ok[ch]),
      .lost(lost[ch]),
      .declare(declare[ch])
    );
  end

  assign RX_SIGNAL_LOST = lost;

  // ****************
  // Alarm status
  // ****************
  always_comb begin
    next_status = status;
    if (status_read) begin
      next_status = next_status & ~read_mask;
    end
    if (clear_write) begin
      next_status = next_status & ~PWDATA[7:0];
    end
    next_status = next_status | declare;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      status <= RLM_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // ****************
  // Interrupt
  // ****************
  assign INT_N = !(|(status & enable));

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_declare_latch: assert property (declare != 8'h00
    |=> (status & $past(declare)) == $past(declare)
     && (lost & $past(declare)) == $past(declare))
    else $error("Declaration missed live flag or status");

  a_irq_level: assert property ((status & enable) != 8'h00
    |-> !INT_N)
    else $error("Interrupt high with enabled alarm");

  a_irq_hold: assert property (!INT_N && (status & enable) != 8'h00
    && !status_read && !clear_write |=> !INT_N)
    else $error("Interrupt released with alarm pending");

  a_read_clears: assert property (status_setup && declare == 8'h00
    ##1 status_read && declare == 8'h00 |=> status == 8'h00)
    else $error("Status not cleared by read");

  a_irq_release: assert property (status_setup && declare == 8'h00
    ##1 status_read && declare == 8'h00 |=> INT_N)
    else $error("Interrupt not released after read");

  a_set_wins: assert property (status_read && declare != 8'h00
    |=> (status & $past(declare)) == $past(declare))
    else $error("New alarm lost under read clear");

  a_read_stable: assert property (setup && !PWRITE
    |=> PRDATA == $past(rlm_read(PADDR, config_reg, lost, status, enable)))
    else $error("Read data not taken in setup");

  a_unmapped_err: assert property (access && !rlm_mapped(PADDR)
    |-> PSLVERR && PREADY)
    else $error("Unmapped access without error");

  a_no_spurious: assert property (##1 1'b1 |-> (lost & ~$past(lost)) == $past(declare))
    else $error("Spurious loss flag");

  a_count_gate_top: assert property (RX_ANALOG_LOW == 8'h00
    |=> declare == 8'h00)
    else $error("Declared loss with no analog condition");

  c_declare: cover property (declare != 8'h00);
  c_irq: cover property (INT_N ##1 !INT_N);
  c_read_release: cover property (status_read ##1 INT_N);
  c_recover: cover property ($fell(RX_SIGNAL_LOST[0]));

endmodule // rlm_top

/* File: rtl/rlm_win.sv */
/*
  Ones-density window checker for one receive channel.
  Assumes bit strobes synchronous to the core clock.
*/
`timescale 1ns/100ps
module rlm_win import rlm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic e1_mode,
  input wire logic bit_valid,
  input wire logic bit_data,
  output logic window_ok
);

  logic [7:0] pos;
  logic [7:0] ones;
  logic [7:0] run;
  logic bad;
  logic [7:0] next_ones;
  logic [7:0] next_run;
  logic next_bad;
  logic [7:0] win_len;

  assign win_len = e1_mode ? RLM_E1_WIN_LEN : RLM_T1_WIN_LEN;
  assign next_ones = ones + {7'h00, bit_data};
  assign next_run = bit_data ? 8'h00 : (run == 8'hFF ? run : run + 8'h01);
  // Run too long anywhere in the window spoils it
  assign next_bad = bad | (next_run > (e1_mode ? RLM_E1_WIN_RUN
                                               : RLM_T1_WIN_RUN));

  // ****************
  // Window walk
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      pos <= 8'h00;
      ones <= 8'h00;
      run <= 8'h00;
      bad <= 1'b0;
      window_ok <= 1'b0;
    end else if (bit_valid) begin
      run <= next_run;
      if (pos == win_len - 8'h01) begin
        pos <= 8'h00;
        ones <= 8'h00;
        bad <= 1'b0;
        window_ok <= !next_bad && next_ones >= (e1_mode ? RLM_E1_WIN_ONES
                                                : RLM_T1_WIN_ONES);
      end else begin
        pos <= pos + 8'h01;
        ones <= next_ones;
        bad <= next_bad;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_run_spoils: assert property (bit_valid && next_run > RLM_E1_WIN_RUN
    && e1_mode && pos == RLM_E1_WIN_LEN - 8'h01 |=> !window_ok)
    else $error("Window passed despite long zero run");

endmodule // rlm_win

/* File: tb/rlm_top_tb.sv */
/*
  Self-checking bench for the loss-of-signal monitor top.
  Assumes zero-wait APB and strobed recovered bits per channel.
*/
`timescale 1ns/100ps
module rlm_top_tb import rlm_pkg::*; ;
  logic clk, rst, psel, pen, pwr;
  logic [7:0] paddr, ana, vld, bits;
  logic [31:0] pwdata, d;
  logic e;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, int_n;
  wire logic [7:0] lost;
  int n_mismatch, check_count;

  rlm_top rlm_top_i (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_ANALOG_LOW(ana), .RX_BIT_VALID(vld), .RX_BIT(bits),
    .RX_SIGNAL_LOST(lost), .INT_N(int_n));

  // ****************
  // Clock and watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #80000;
    n_mismatch++;
    wrap_up;
  end

  // ****************
  // Tasks
  // ****************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (t >= 20) begin
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask

  // Feed n bits; a one every per bits, none when per is 0
  task automatic feed(input int ch, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      vld[ch] <= 1'b1;
      bits[ch] <= (per != 0) && (i % per == per - 1);
    end
    @(posedge clk);
    vld[ch] <= 1'b0;
  endtask

  task automatic lost_is(input logic [7:0] exp);
    #1;
    chk({24'h0, lost}, {24'h0, exp});
  endtask

  task automatic int_is(input logic exp);
    #1;
    chk({31'h0, int_n}, {31'h0, exp});
  endtask

  task automatic set_ana(input logic [7:0] v);
    @(posedge clk);
    ana <= v;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ana = 8'h00;
    vld = 8'h00;
    bits = 8'h00;
    n_mismatch = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values and unmapped address
    rd_chk(RLM_OFS_CONFIG, 32'h0);
    rd_chk(RLM_OFS_LIVE, 32'h0);
    rd_chk(RLM_OFS_STATUS, 32'h0);
    rd_chk(RLM_OFS_ENABLE, 32'h0);
    rd_chk(RLM_OFS_CLEAR, 32'h0);
    chk({31'h0, pready}, 32'h1);
    int_is(1'b1);
    apb(1'b1, 8'h14, 32'hFFFFFFFF, d, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h14, 32'h0, d, e);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(RLM_OFS_ENABLE, 32'h62);
    rd_chk(RLM_OFS_ENABLE, 32'h62);
    // T1 zeros without analog low
    feed(0, 200, 0);
    lost_is(8'h00);
    // A one restarts the run
    set_ana(8'h04);
    feed(2, 150, 0);
    feed(2, 1, 1);
    feed(2, 150, 0);
    lost_is(8'h00);
    // T1 declaration at 175 zeros
    set_ana(8'h02);
    feed(1, 174, 0);
    lost_is(8'h00);
    int_is(1'b1);
    feed(1, 1, 0);
    lost_is(8'h02);
    int_is(1'b0);
    rd_chk(RLM_OFS_LIVE, 32'h02);
    rd_chk(RLM_OFS_STATUS, 32'h02);
    int_is(1'b1);
    rd_chk(RLM_OFS_STATUS, 32'h00);
    lost_is(8'h02);
    // T1 clear needs density and level
    feed(1, 256, 9);
    set_ana(8'h00);
    repeat (3) @(posedge clk);
    lost_is(8'h02);
    feed(1, 256, 8);
    lost_is(8'h00);
    // E1 declaration at 32 zeros
    wr(RLM_OFS_CONFIG, 32'h1);
    rd_chk(RLM_OFS_CONFIG, 32'h1);
    set_ana(8'h08);
    feed(3, 31, 0);
    lost_is(8'h00);
    feed(3, 1, 0);
    lost_is(8'h08);
    int_is(1'b1);
    feed(3, 64, 8);
    lost_is(8'h08);
    set_ana(8'h00);
    repeat (3) @(posedge clk);
    lost_is(8'h00);
    // E1 extended window
    wr(RLM_OFS_CONFIG, 32'h3);
    rd_chk(RLM_OFS_CONFIG, 32'h3);
    set_ana(8'h10);
    feed(4, 4095, 0);
    lost_is(8'h00);
    feed(4, 1, 0);
    lost_is(8'h10);
    // Several enabled channels pending
    wr(RLM_OFS_CONFIG, 32'h1);
    set_ana(8'hF0);
    feed(5, 32, 0);
    feed(6, 32, 0);
    feed(7, 32, 0);
    lost_is(8'hF0);
    int_is(1'b0);
    wr(RLM_OFS_CLEAR, 32'h20);
    int_is(1'b0);
    rd_chk(RLM_OFS_STATUS, 32'hD8);
    int_is(1'b1);
    rd_chk(RLM_OFS_STATUS, 32'h00);
    wrap_up;
  end
endmodule // rlm_top_tb
